/* logic/msf_data_fifo.sv */
// Sample batching store of the motion sensor: set sequencer, decimation,
// operating modes, watermark, status and the host read-out pair.
// Assumes register accesses are single-cycle strobes on sys_clk.

`timescale 1ns/10ps
`default_nettype none

module msf_data_fifo
#(
  parameter int DEPTH_WORDS = msf_pkg::MSF_CAP_BYTES / msf_pkg::MSF_WORD_BYTES
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic stop_at_watermark,
  input wire logic hub_trigger_sel,
  input wire logic ds4_temp_sel,
  input wire logic mode_switch_event,
  input wire msf_pkg::msf_route_t line_one_route_ctl,
  input wire msf_pkg::msf_route_t line_two_route_ctl,
  input wire logic sensor_drdy,
  input wire logic hub_cycle_done,
  input wire logic step_detected,
  input wire msf_pkg::msf_sets_t sample_sets,
  input wire logic [47:0] step_stamp,
  input wire logic [47:0] temperature,
  output logic interrupt_line_one,
  output logic interrupt_line_two
);

  localparam int AW = $clog2(DEPTH_WORDS);
  localparam int NWORDS = msf_pkg::MSF_SETS * msf_pkg::MSF_SET_WORDS;

  if (DEPTH_WORDS < 4 || (DEPTH_WORDS & (DEPTH_WORDS - 1)) != 0 ||
      DEPTH_WORDS > (1 << msf_pkg::MSF_WM_BITS))
  begin : g_bad_depth
    $error("msf_data_fifo: DEPTH_WORDS must be a power of two, 4 to 4096");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [7:0] wm_low_q;
  logic [7:0] wm_high_q;
  logic [7:0] sens_dec_q;
  logic [7:0] extra_dec_q;
  logic [7:0] mode_ctl_q;
  logic [11:0] watermark_level;
  logic [2:0] mode;

  assign watermark_level = {wm_high_q[3:0], wm_low_q};
  assign mode = mode_ctl_q[msf_pkg::MSF_MODE_LSB +: 3];

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wm_low_q <= msf_pkg::MSF_CTRL_RESET;
      wm_high_q <= msf_pkg::MSF_CTRL_RESET;
      sens_dec_q <= msf_pkg::MSF_CTRL_RESET;
      extra_dec_q <= msf_pkg::MSF_CTRL_RESET;
      mode_ctl_q <= msf_pkg::MSF_CTRL_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        msf_pkg::MSF_ADDR_WM_LOW: wm_low_q <= reg_wdata;
        msf_pkg::MSF_ADDR_WM_HIGH: wm_high_q <= reg_wdata & 8'hcf;
        msf_pkg::MSF_ADDR_SENS_DEC: sens_dec_q <= reg_wdata & 8'h3f;
        msf_pkg::MSF_ADDR_EXTRA_DEC: extra_dec_q <= reg_wdata & 8'h7f;
        msf_pkg::MSF_ADDR_MODE: mode_ctl_q <= reg_wdata & 8'h7f;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode

  logic fifo_on;
  logic fifo_cont;

  // A zero rate field also disables the store; reserved codes act as bypass
  always_comb
  begin
    fifo_on = 1'b0;
    fifo_cont = 1'b0;
    case (mode)
      msf_pkg::MSF_MODE_STOP:
      begin
        fifo_on = 1'b1;
      end
      msf_pkg::MSF_MODE_CONT:
      begin
        fifo_on = 1'b1;
        fifo_cont = 1'b1;
      end
      msf_pkg::MSF_MODE_CONT_TO_STOP:
      begin
        fifo_on = 1'b1;
        fifo_cont = !mode_switch_event;
      end
      msf_pkg::MSF_MODE_BYP_TO_CONT:
      begin
        fifo_on = mode_switch_event;
        fifo_cont = 1'b1;
      end
      default:
      begin
        fifo_on = 1'b0;
        fifo_cont = 1'b0;
      end
    endcase
    if (mode_ctl_q[msf_pkg::MSF_RATE_LSB +: 4] == 4'h0)
      fifo_on = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger, decimation and snapshot

  logic high_only;
  logic trig;
  logic take;
  logic [5:0] factor [msf_pkg::MSF_SETS];
  logic [5:0] dec_cnt_q [msf_pkg::MSF_SETS];
  logic [3:0] store_mask;
  msf_pkg::msf_sets_t snap_d;
  msf_pkg::msf_seq_t seq_q;

  assign high_only = extra_dec_q[msf_pkg::MSF_HIGH_ONLY_BIT];

  always_comb
  begin
    if (hub_trigger_sel)
      trig = hub_cycle_done;
    else if (wm_high_q[msf_pkg::MSF_STEP_TRIG_BIT])
      trig = step_detected;
    else
      trig = sensor_drdy;
  end

  // Triggers arriving while a snapshot is still being emitted are not queued
  assign take = trig && fifo_on && (seq_q == msf_pkg::MSF_SEQ_IDLE);

  assign factor[0] = msf_pkg::msf_dec_factor(sens_dec_q[msf_pkg::MSF_DEC_HI_LSB +: 3]);
  assign factor[1] = msf_pkg::msf_dec_factor(sens_dec_q[msf_pkg::MSF_DEC_LO_LSB +: 3]);
  assign factor[2] = msf_pkg::msf_dec_factor(extra_dec_q[msf_pkg::MSF_DEC_LO_LSB +: 3]);
  assign factor[3] = msf_pkg::msf_dec_factor(extra_dec_q[msf_pkg::MSF_DEC_HI_LSB +: 3]);

  always_comb
  begin
    for (int s = 0; s < msf_pkg::MSF_SETS; s++)
      store_mask[s] = (factor[s] != 6'h00) && (dec_cnt_q[s] == 6'h00);
    if (high_only)
      store_mask[1] = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !fifo_on)
    begin
      for (int s = 0; s < msf_pkg::MSF_SETS; s++)
        dec_cnt_q[s] <= 6'h00;
    end
    else if (take)
    begin
      for (int s = 0; s < msf_pkg::MSF_SETS; s++)
      begin
        if (dec_cnt_q[s] + 6'h01 >= factor[s])
          dec_cnt_q[s] <= 6'h00;
        else
          dec_cnt_q[s] <= dec_cnt_q[s] + 6'h01;
      end
    end
  end

  always_comb
  begin
    snap_d.gyro = sample_sets.gyro;
    snap_d.accel = sample_sets.accel;
    snap_d.hub_low = sample_sets.hub_low;
    if (high_only)
      snap_d.gyro = {sample_sets.accel[47:40], sample_sets.accel[31:24],
                     sample_sets.accel[15:8], sample_sets.gyro[47:40],
                     sample_sets.gyro[31:24], sample_sets.gyro[15:8]};
    if (wm_high_q[msf_pkg::MSF_STEP_SET_BIT])
      snap_d.ds4 = step_stamp;
    else if (ds4_temp_sel)
      snap_d.ds4 = temperature;
    else
      snap_d.ds4 = sample_sets.ds4;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set sequencer

  logic [191:0] snap_q;
  logic [3:0] mask_q;
  logic [3:0] idx_q;
  logic [1:0] set_idx;
  logic seq_valid;
  logic buf_in_ready;

  assign set_idx = 2'(idx_q / 4'h3);
  assign seq_valid = (seq_q == msf_pkg::MSF_SEQ_EMIT) && mask_q[set_idx];

  always_ff @(posedge sys_clk)
  begin
    if (reset || !fifo_on)
    begin
      seq_q <= msf_pkg::MSF_SEQ_IDLE;
      idx_q <= 4'h0;
      mask_q <= 4'h0;
      snap_q <= '0;
    end
    else
    begin
      case (seq_q)
        msf_pkg::MSF_SEQ_IDLE:
        begin
          if (take && (store_mask != 4'h0))
          begin
            snap_q <= snap_d;
            mask_q <= store_mask;
            idx_q <= 4'h0;
            seq_q <= msf_pkg::MSF_SEQ_EMIT;
          end
        end
        msf_pkg::MSF_SEQ_EMIT:
        begin
          // Disabled sets are skipped one word slot per cycle
          if (!seq_valid || buf_in_ready)
          begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'(NWORDS - 1))
              seq_q <= msf_pkg::MSF_SEQ_IDLE;
          end
        end
        default: seq_q <= msf_pkg::MSF_SEQ_IDLE;
      endcase
    end
  end

  logic buf_out_valid;
  logic buf_out_ready;
  logic [15:0] buf_out_data;

  msf_pair_buf #(.WIDTH(16), .DEPTH(2)) u_pair_buf
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(seq_valid),
    .in_ready(buf_in_ready),
    .in_data(snap_q[{idx_q, 4'h0} +: 16]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sample store

  logic [15:0] mem_q [DEPTH_WORDS];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [12:0] limit;
  logic push;
  logic pop;
  logic space;
  logic overwrite;
  logic [15:0] head;
  logic latch_valid_q;
  logic [15:0] latch_q;
  logic overrun_q;
  logic full_flag;
  logic wm_flag;
  logic empty_flag;

  // Writes stall for the one cycle in which the host pops the head word
  assign pop = reg_rd && (reg_addr == msf_pkg::MSF_ADDR_OUT_HIGH) && latch_valid_q &&
               (count_q != '0) && fifo_on;
  assign buf_out_ready = !pop;
  assign push = buf_out_valid && buf_out_ready && fifo_on;
  // Compared at full watermark width so a level above a small depth is not truncated
  assign limit = stop_at_watermark ? {1'b0, watermark_level} : 13'(DEPTH_WORDS);
  assign space = (13'(count_q) < limit) && (count_q < (AW+1)'(DEPTH_WORDS));
  assign overwrite = push && !space && fifo_cont && (count_q != '0);
  assign head = (count_q != '0) ? mem_q[rd_ptr_q] : 16'h0000;

  always_ff @(posedge sys_clk)
  begin
    if (push && (space || overwrite))
      mem_q[wr_ptr_q] <= buf_out_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !fifo_on)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (pop)
    begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q - 1'b1;
    end
    else if (push && space)
    begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      count_q <= count_q + 1'b1;
    end
    else if (overwrite)
    begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and read-out

  assign wm_flag = (13'(count_q) >= {1'b0, watermark_level});
  assign full_flag = !space;
  assign empty_flag = (count_q == '0);

  // Set wins over the clear of a status read in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      overrun_q <= 1'b0;
    else if (overwrite)
      overrun_q <= 1'b1;
    else if (reg_rd && (reg_addr == msf_pkg::MSF_ADDR_STATE2))
      overrun_q <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      interrupt_line_one <= 1'b0;
      interrupt_line_two <= 1'b0;
    end
    else
    begin
      interrupt_line_one <= |({overrun_q, wm_flag, full_flag} & line_one_route_ctl);
      interrupt_line_two <= |({overrun_q, wm_flag, full_flag} & line_two_route_ctl);
    end
  end

  logic [12:0] count_ext;
  logic [7:0] state2;

  assign count_ext = 13'(count_q);
  always_comb
  begin
    state2 = {4'h0, count_ext[11:8]};
    state2[msf_pkg::MSF_ST_WM_BIT] = wm_flag;
    state2[msf_pkg::MSF_ST_OVR_BIT] = overrun_q;
    state2[msf_pkg::MSF_ST_FULL_BIT] = full_flag;
    state2[msf_pkg::MSF_ST_EMPTY_BIT] = empty_flag;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      latch_q <= 16'h0000;
      latch_valid_q <= 1'b0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        msf_pkg::MSF_ADDR_WM_LOW: reg_rdata <= wm_low_q;
        msf_pkg::MSF_ADDR_WM_HIGH: reg_rdata <= wm_high_q;
        msf_pkg::MSF_ADDR_SENS_DEC: reg_rdata <= sens_dec_q;
        msf_pkg::MSF_ADDR_EXTRA_DEC: reg_rdata <= extra_dec_q;
        msf_pkg::MSF_ADDR_MODE: reg_rdata <= mode_ctl_q;
        msf_pkg::MSF_ADDR_STATE1: reg_rdata <= count_ext[7:0];
        msf_pkg::MSF_ADDR_STATE2: reg_rdata <= state2;
        msf_pkg::MSF_ADDR_STATE3: reg_rdata <= 8'(rd_ptr_q);
        msf_pkg::MSF_ADDR_STATE4: reg_rdata <= {7'h00, count_ext[12]};
        msf_pkg::MSF_ADDR_OUT_LOW:
        begin
          reg_rdata <= head[7:0];
          latch_q <= head;
          latch_valid_q <= !empty_flag;
        end
        msf_pkg::MSF_ADDR_OUT_HIGH:
        begin
          reg_rdata <= latch_q[15:8];
          latch_valid_q <= 1'b0;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

/* logic/msf_pair_buf.sv */
// Small valid/ready buffer between the set sequencer and the sample store.
// Assumes both sides on sys_clk; out_data is held in flip-flops.

`timescale 1ns/10ps
`default_nettype none

module msf_pair_buf
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("msf_pair_buf: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q < (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = slot_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      slot_q[wr_q] <= in_data;
  end

endmodule

`default_nettype wire

/* logic/msf_pkg.sv */
// Constants, carrier types and helpers of the motion sensor data buffer.
// Assumes byte-wide register access through the device's own register port.
//
// Contract
// - Keep an 8 kbyte sample store.
// - Four 6-byte sets: gyro, then accelerometer.
// - Third set carries hub results one to six.
// - Fourth set: hub high, step stamp or temperature.
// - Per-set decimation; disabling code drops the set.
// - Codes 000 off, 001 none, then 2..32.
// - Three-bit mode field picks five behaviours.
// - Mode codes decode; other codes are reserved.
// - Host reads words through low/high pair.
// - Four status registers: full, empty, count.
// - Twelve-bit watermark split over two registers.
// - Watermark counts 16-bit words.
// - Watermark flag when stored >= watermark.
// - Stop-at-watermark limits depth to watermark.
// - Full, watermark, overrun routed to two lines.
// - MSB-only stores upper bytes of gyro/accel.
// - Hub select bit switches trigger to hub-done.
// - Step store bit triggers storage on steps.
// - Low watermark register holds bits 7..0.

package msf_pkg;

  localparam logic [6:0] MSF_ADDR_WM_LOW = 7'h06;
  localparam logic [6:0] MSF_ADDR_WM_HIGH = 7'h07;
  localparam logic [6:0] MSF_ADDR_SENS_DEC = 7'h08;
  localparam logic [6:0] MSF_ADDR_EXTRA_DEC = 7'h09;
  localparam logic [6:0] MSF_ADDR_MODE = 7'h0a;
  localparam logic [6:0] MSF_ADDR_STATE1 = 7'h3a;
  localparam logic [6:0] MSF_ADDR_STATE2 = 7'h3b;
  localparam logic [6:0] MSF_ADDR_STATE3 = 7'h3c;
  localparam logic [6:0] MSF_ADDR_STATE4 = 7'h3d;
  localparam logic [6:0] MSF_ADDR_OUT_LOW = 7'h3e;
  localparam logic [6:0] MSF_ADDR_OUT_HIGH = 7'h3f;

  localparam int MSF_STEP_SET_BIT = 7;
  localparam int MSF_STEP_TRIG_BIT = 6;
  localparam int MSF_HIGH_ONLY_BIT = 6;
  localparam int MSF_DEC_LO_LSB = 0;
  localparam int MSF_DEC_HI_LSB = 3;
  localparam int MSF_MODE_LSB = 0;
  localparam int MSF_RATE_LSB = 3;
  localparam int MSF_ST_WM_BIT = 7;
  localparam int MSF_ST_OVR_BIT = 6;
  localparam int MSF_ST_FULL_BIT = 5;
  localparam int MSF_ST_EMPTY_BIT = 4;

  localparam logic [7:0] MSF_CTRL_RESET = 8'h00;
  localparam int MSF_CAP_BYTES = 8192;
  localparam int MSF_WORD_BYTES = 2;
  localparam int MSF_SET_WORDS = 3;
  localparam int MSF_SETS = 4;
  localparam int MSF_WM_BITS = 12;

  typedef enum logic [2:0]
  {
    MSF_MODE_BYPASS = 3'b000,
    MSF_MODE_STOP = 3'b001,
    MSF_MODE_CONT_TO_STOP = 3'b011,
    MSF_MODE_BYP_TO_CONT = 3'b100,
    MSF_MODE_CONT = 3'b110
  } msf_mode_t;

  typedef enum logic [0:0]
  {
    MSF_SEQ_IDLE = 1'b0,
    MSF_SEQ_EMIT = 1'b1
  } msf_seq_t;

  // Gyro sits in the low bits so word k of a snapshot is bits 16k+15..16k
  typedef struct packed {
    logic [47:0] ds4;
    logic [47:0] hub_low;
    logic [47:0] accel;
    logic [47:0] gyro;
  } msf_sets_t;

  typedef struct packed {
    logic overrun;
    logic watermark;
    logic full;
  } msf_route_t;

  function automatic logic [5:0] msf_dec_factor(input logic [2:0] code);
    case (code)
      3'h0: msf_dec_factor = 6'h00;
      3'h1: msf_dec_factor = 6'h01;
      3'h2: msf_dec_factor = 6'h02;
      3'h3: msf_dec_factor = 6'h03;
      3'h4: msf_dec_factor = 6'h04;
      3'h5: msf_dec_factor = 6'h08;
      3'h6: msf_dec_factor = 6'h10;
      default: msf_dec_factor = 6'h20;
    endcase
  endfunction

endpackage

/* verification/msf_data_fifo_chk.sv */
// Checker for the register port and interrupt lines of the sample store.
// Assumes it is bound to msf_data_fifo and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module msf_data_fifo_chk
#(
  parameter int DEPTH_WORDS = 4096
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire msf_pkg::msf_route_t line_one_route_ctl,
  input wire msf_pkg::msf_route_t line_two_route_ctl,
  input wire logic interrupt_line_one,
  input wire logic interrupt_line_two
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Writable bits per control register; anything else reads as zero
  function automatic logic [7:0] wmask(input logic [6:0] a);
    case (a)
      7'h07: wmask = 8'hcf;
      7'h08: wmask = 8'h3f;
      7'h09: wmask = 8'h7f;
      7'h0a: wmask = 8'h7f;
      default: wmask = 8'hff;
    endcase
  endfunction

  logic mapped;
  assign mapped = reg_addr inside {[7'h06:7'h0a], [7'h3a:7'h3f]};

  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  ctrl_back_a: assert property (reg_wr && reg_addr inside {[7'h06:7'h0a]} ##2
    reg_rd && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata == ($past(reg_wdata, 3) & wmask($past(reg_addr, 3))))
    else $error("control register did not read back");
  reserved_zero_a: assert property (reg_rd |=> (reg_rdata & ~wmask($past(reg_addr))) == 8'h00)
    else $error("reserved bit read as one");
  line_one_quiet_a: assert property (line_one_route_ctl == 3'b000 |=> !interrupt_line_one)
    else $error("line one raised with no route");
  line_two_quiet_a: assert property (line_two_route_ctl == 3'b000 |=> !interrupt_line_two)
    else $error("line two raised with no route");
  bypass_clear_a: assert property (reg_wr && reg_addr == 7'h0a && reg_wdata[2:0] == 3'b000
    ##2 reg_rd && reg_addr == 7'h3a |=> reg_rdata == 8'h00)
    else $error("bypass left samples stored");
  empty_count_a: assert property (reg_rd && reg_addr == 7'h3b |=>
    !reg_rdata[4] || reg_rdata[3:0] == 4'h0)
    else $error("empty with nonzero count");
  reset_quiet_a: assert property ($fell(reset) |->
    !interrupt_line_one && !interrupt_line_two && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");

  cover property (reg_rd && reg_addr == 7'h3f);
  cover property (interrupt_line_two);
  cover property (reg_wr && reg_addr == 7'h0a && reg_wdata[2:0] == 3'b110);
endmodule
bind msf_data_fifo msf_data_fifo_chk #(.DEPTH_WORDS(DEPTH_WORDS)) chk_u (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .line_one_route_ctl(line_one_route_ctl), .line_two_route_ctl(line_two_route_ctl),
  .interrupt_line_one(interrupt_line_one), .interrupt_line_two(interrupt_line_two));
`default_nettype wire

/* verification/msf_data_fifo_tb_top.sv */
// Self-checking bench of the sample store: registers, triggers, modes, readout.
// Assumes a store depth of 128 words so overrun is reached quickly.
`timescale 1ns/10ps
`default_nettype none
module msf_data_fifo_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic stop_wm = 1'b0;
  logic hub_sel = 1'b0;
  logic drdy = 1'b0;
  logic hub_done = 1'b0;
  logic step = 1'b0;
  logic ds4_sel = 1'b0;
  logic mode_ev = 1'b0;
  logic [191:0] hv;
  logic irq1;
  logic irq2;
  msf_pkg::msf_route_t route1 = 3'b000;
  msf_pkg::msf_route_t route2 = 3'b000;
  msf_pkg::msf_sets_t sets;
  logic [47:0] stamp;
  logic [47:0] temp;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  logic [6:0] regs[5] = '{7'h06, 7'h07, 7'h08, 7'h09, 7'h0a};
  logic [7:0] masks[5] = '{8'hff, 8'hcf, 8'h3f, 8'h7f, 8'h7f};
  int fac[8] = '{0, 1, 2, 3, 4, 8, 16, 32};

  always #20 sys_clk = ~sys_clk;

  msf_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  msf_data_fifo #(.DEPTH_WORDS(128)) dut_u (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .stop_at_watermark(stop_wm), .hub_trigger_sel(hub_sel),
    .ds4_temp_sel(ds4_sel), .mode_switch_event(mode_ev), .line_one_route_ctl(route1),
    .line_two_route_ctl(route2), .sensor_drdy(drdy), .hub_cycle_done(hub_done),
    .step_detected(step), .sample_sets(sets), .step_stamp(stamp), .temperature(temp),
    .interrupt_line_one(irq1), .interrupt_line_two(irq2));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, 0);
  endtask

  // Data reads get a random host delay to exercise read-data holding
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(1'b0, a, 8'h00, (a >= 7'h3e) ? $urandom_range(0, 1) : 0);
  endtask

  // Waits out the set emission so no trigger lands in the busy window
  task automatic fire(input int kind, input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      drdy = (kind == 0);
      hub_done = (kind == 1);
      step = (kind == 2);
      @(negedge sys_clk);
      {drdy, hub_done, step} = 3'b000;
      repeat (18) @(negedge sys_clk);
    end
  endtask

  task automatic restart(input logic [7:0] mode);
    wr(7'h0a, 8'h00);
    rd(7'h3a, 8'h00);
    wr(7'h0a, mode);
  endtask

  // Pops n words and expects them in order from the low end of v
  task automatic pull(input logic [191:0] v, input int n);
    for (int k = 0; k < n; k++)
    begin
      rd(7'h3e, v[16*k +: 8]);
      rd(7'h3f, v[16*k+8 +: 8]);
    end
  endtask

  always @(posedge sys_clk)
    rd_pend <= reg_rd;

  always @(negedge sys_clk)
    if (rd_pend && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());

  // Whole run is a few thousand cycles; this margin only cuts a hang
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    summarize();
  end

  initial
  begin
    void'($urandom(32'h584e));
    sets = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    stamp = 48'($urandom);
    temp = 48'($urandom);
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(7'h3b, 8'h90);
    rd(7'h20, 8'h00);
    foreach (regs[i])
    begin
      wr(regs[i], 8'hff);
      rd(regs[i], masks[i]);
    end
    $display("test registers done");
    wr(7'h06, 8'h14);
    wr(7'h07, 8'h00);
    wr(7'h08, 8'h09);
    wr(7'h09, 8'h09);
    route1 = 3'b010;
    route2 = 3'b101;
    restart(8'h0e);
    fire(0, 1);
    rd(7'h3a, 8'h0c);
    rd(7'h3b, 8'h00);
    check({7'h00, irq1}, 8'h00);
    pull(sets, 12);
    rd(7'h3b, 8'h10);
    rd(7'h3e, 8'h00);
    $display("test readout done");
    wr(7'h09, 8'h00);
    for (int c = 1; c < 8; c++)
    begin
      wr(7'h08, {2'b00, 3'(c), 3'b001});
      restart(8'h09);
      fire(0, fac[c]);
      rd(7'h3a, 8'(3 * fac[c] + 3));
    end
    $display("test decimation done");
    wr(7'h08, 8'h09);
    wr(7'h09, 8'h09);
    wr(7'h06, 8'h0a);
    wr(7'h07, 8'h40);
    stop_wm = 1'b1;
    restart(8'h09);
    fire(2, 1);
    rd(7'h3a, 8'h0a);
    rd(7'h3b, 8'ha0);
    check({7'h00, irq1}, 8'h01);
    check({7'h00, irq2}, 8'h01);
    $display("test watermark stop done");
    stop_wm = 1'b0;
    hub_sel = 1'b1;
    restart(8'h0e);
    fire(1, 11);
    rd(7'h3a, 8'h80);
    rd(7'h3b, 8'he0);
    rd(7'h3b, 8'ha0);
    rd(7'h3e, sets[16*4 +: 8]);
    repeat (4) @(negedge sys_clk);
    $display("test overrun done");
    hub_sel = 1'b0;
    wr(7'h07, 8'h80);
    wr(7'h09, 8'h49);
    restart(8'h09);
    fire(0, 1);
    rd(7'h3a, 8'h09);
    for (int j = 0; j < 6; j++)
      hv[8*j +: 8] = sets[16*j+8 +: 8];
    hv[191:48] = {48'h0, stamp, sets[143:96]};
    pull(hv, 9);
    wr(7'h07, 8'h00);
    wr(7'h08, 8'h00);
    wr(7'h09, 8'h08);
    ds4_sel = 1'b1;
    restart(8'h09);
    fire(0, 1);
    pull({144'h0, temp}, 3);
    $display("test fourth set done");
    restart(8'h0c);
    fire(0, 1);
    rd(7'h3a, 8'h00);
    mode_ev = 1'b1;
    fire(0, 1);
    rd(7'h3a, 8'h03);
    stop_wm = 1'b1;
    restart(8'h0b);
    fire(0, 4);
    rd(7'h3b, 8'ha0);
    mode_ev = 1'b0;
    fire(0, 1);
    rd(7'h3b, 8'he0);
    $display("test switching modes done");
    summarize();
  end
endmodule
`default_nettype wire

/* verification/msf_host_model.sv */
// Host side of the register port: single-cycle read and write strobes.
// Assumes the device samples strobes on the rising edge of sys_clk.
`timescale 1ns/10ps
`default_nettype none
module msf_host_model
(
  input wire logic sys_clk,
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // A slow host waits gap cycles; released address and data lines show inverted values, strobes drop low
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire
